// >>> rtl/afe_pkg.sv
// constants for the front end setup registers and sample strobe detector
// ==========================================================================
// Summary of operation
// RL1 - latency 01 adds one, 11 adds three periods
// RL2 - converter period two clocks, three in mode two
// RL3 - clamp level code bits 3:0, resets ones
// RL4 - reset sample shift bits 5:4, default nominal
// RL5 - host writes zeros to reserved bits
// RL6 - any soft reset write clears all state; the code keeps the pready, pslverr and prdata of the write in flight
// RL7 - host soft resets first after power up
// RL8 - clamp enable bit 3, default off
// RL9 - colour select bits 5:4, 11 reserved
// RL10 - colour select picks offset and gain values
// RL11 - detect off passes strobe, on makes pulse
// RL12 - pulse lags edge by delay field clocks
// RL13 - delay and polarity ignored while detect off
// RL14 - polarity bit chooses falling or rising edge
// RL15 - one clock wide pulse per qualifying edge
// RL16 - strobe sampled each clock, compared with previous
package afe_pkg;
    // ======================================================================
    // bus and register indices, byte address is four times the index
    localparam int APB_AW = 8;
    localparam logic [5:0] IDX_SETUP2 = 6'h02;
    localparam logic [5:0] IDX_SETUP3 = 6'h03;
    localparam logic [5:0] IDX_SOFT_RST = 6'h04;
    localparam logic [5:0] IDX_SETUP4 = 6'h06;
    localparam logic [5:0] IDX_SETUP5 = 6'h08;
    localparam logic [5:0] IDX_MODE = 6'h0D;
    // ======================================================================
    // field positions
    localparam int LAT_LSB = 6;
    localparam int CLAMP_LVL_LSB = 0;
    localparam int RS_SHIFT_LSB = 4;
    localparam int CLAMP_EN_BIT = 3;
    localparam int COLOUR_LSB = 4;
    localparam int DET_EN_BIT = 0;
    localparam int DLY_LSB = 1;
    localparam int POL_BIT = 4;
    localparam int MODE2_BIT = 0;
    // ======================================================================
    // reset values
    localparam logic [1:0] LAT_RST = 2'h0;
    localparam logic [5:0] S2_OTHER_RST = 6'h23;
    localparam logic [3:0] CLAMP_LVL_RST = 4'hF;
    localparam logic [1:0] RS_SHIFT_RST = 2'h1;
    localparam logic CLAMP_EN_RST = 1'b0;
    localparam logic [1:0] COLOUR_RST = 2'h0;
    localparam logic DET_EN_RST = 1'b0;
    localparam logic [2:0] DLY_RST = 3'h0;
    localparam logic POL_RST = 1'b0;
    localparam logic MODE2_RST = 1'b0;
    localparam logic [2:0] S4_FIXED = 3'h5;
    // ======================================================================
    // colour codes and converter period in master clocks
    localparam logic [1:0] COLOUR_RED = 2'h0;
    localparam logic [1:0] COLOUR_GREEN = 2'h1;
    localparam logic [1:0] COLOUR_BLUE = 2'h2;
    localparam logic [1:0] CONV_PER_NORMAL = 2'h2;
    localparam logic [1:0] CONV_PER_MODE2 = 2'h3;
    localparam int STROBE_DLY_MAX = 8;
endpackage

// >>> rtl/afe_setup_regs.sv
// setup registers, latency pipe and strobe selection of the front end
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module afe_setup_regs #(
    parameter int DATA_W = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [afe_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [DATA_W-1:0] conv_data_in,
    output logic [DATA_W-1:0] conv_data_out,
    output logic conv_tick,
    input wire logic sample_strobe_in,
    output logic timing_strobe,
    output logic [3:0] clamp_level_code,
    output logic [1:0] reset_sample_shift,
    output logic reset_level_clamping,
    output logic [1:0] colour_select,
    input wire logic [7:0] offset_red,
    input wire logic [7:0] offset_green,
    input wire logic [7:0] offset_blue,
    input wire logic [7:0] gain_red,
    input wire logic [7:0] gain_green,
    input wire logic [7:0] gain_blue,
    output logic [7:0] offset_active,
    output logic [7:0] gain_active
);
    import afe_pkg::*;

    // ======================================================================
    // state of the whole block
    typedef struct packed {
        logic [1:0] lat;
        logic [5:0] s2_other;
        logic [3:0] clamp_lvl;
        logic [1:0] rs_shift;
        logic clamp_en;
        logic [1:0] colour;
        logic det_en;
        logic [2:0] dly;
        logic pol;
        logic mode2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0] conv_cnt;
        logic conv_tick;
        logic [3:0][DATA_W-1:0] pipe;
        logic [DATA_W-1:0] data_out;
        logic strobe_out;
        logic [7:0] offset_sel;
        logic [7:0] gain_sel;
    } afe_regs_state_s;

    afe_regs_state_s s_r;
    afe_regs_state_s s_nxt;
    logic setup_phase;
    logic wr_go;
    logic soft_go;
    logic mapped;
    logic det_pulse;
    logic det_clear;
    logic [31:0] rd_word;

    // ======================================================================
    // helpers
    // address match of one register index
    function automatic logic reg_hit(input logic [APB_AW-1:0] addr,
                                     input logic [5:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    // per colour value select, reserved code falls back to red
    function automatic logic [7:0] pick_colour(input logic [1:0] colour,
                                               input logic [7:0] red,
                                               input logic [7:0] green,
                                               input logic [7:0] blue);
        unique case (colour)
            COLOUR_GREEN: pick_colour = green;
            COLOUR_BLUE: pick_colour = blue;
            default: pick_colour = red;
        endcase
    endfunction

    // reset value of every field
    function automatic afe_regs_state_s state_reset();
        afe_regs_state_s v;
        v = '0;
        v.lat = LAT_RST;
        v.s2_other = S2_OTHER_RST;
        v.clamp_lvl = CLAMP_LVL_RST; // RL3
        v.rs_shift = RS_SHIFT_RST; // RL4
        v.clamp_en = CLAMP_EN_RST; // RL8
        v.colour = COLOUR_RST; // RL9
        v.det_en = DET_EN_RST;
        v.dly = DLY_RST;
        v.pol = POL_RST;
        v.mode2 = MODE2_RST;
        state_reset = v;
    endfunction

    // ======================================================================
    // bus decode
    assign setup_phase = psel && !penable;
    assign wr_go = psel && penable && pwrite && s_r.pready;
    assign soft_go = wr_go && reg_hit(paddr, IDX_SOFT_RST); // RL6
    assign mapped = reg_hit(paddr, IDX_SETUP2) ||
                    reg_hit(paddr, IDX_SETUP3) ||
                    reg_hit(paddr, IDX_SOFT_RST) ||
                    reg_hit(paddr, IDX_SETUP4) ||
                    reg_hit(paddr, IDX_SETUP5) ||
                    reg_hit(paddr, IDX_MODE);

    // read mux, reserved bits read as their fixed values
    always_comb begin
        rd_word = '0;
        if (reg_hit(paddr, IDX_SETUP2)) begin
            rd_word[7:0] = {s_r.lat, s_r.s2_other};
        end
        if (reg_hit(paddr, IDX_SETUP3)) begin
            rd_word[7:0] = {2'b00, s_r.rs_shift, s_r.clamp_lvl};
        end
        if (reg_hit(paddr, IDX_SETUP4)) begin
            rd_word[7:0] = {2'b00, s_r.colour, s_r.clamp_en, S4_FIXED};
        end
        if (reg_hit(paddr, IDX_SETUP5)) begin
            rd_word[7:0] = {3'b000, s_r.pol, s_r.dly, s_r.det_en};
        end
        if (reg_hit(paddr, IDX_MODE)) begin
            rd_word[MODE2_BIT] = s_r.mode2;
        end
    end

    // ======================================================================
    // strobe edge detector, cleared by reset or a soft reset write, pulse held low while detection is off
    assign det_clear = reset || soft_go;

    afe_strobe_det u_strobe_det (
        .clock(clock),
        .clear(det_clear),
        .enable(s_r.det_en),
        .strobe_in(sample_strobe_in),
        .polarity(s_r.pol),
        .delay(s_r.dly),
        .pulse(det_pulse)
    );

    // ======================================================================
    // next state
    always_comb begin
        afe_regs_state_s v;
        logic [1:0] per;
        v = state_reset();
        per = CONV_PER_NORMAL;
        s_nxt = s_r;
        // answer one cycle after setup, no wait states
        s_nxt.pready = setup_phase;
        s_nxt.pslverr = setup_phase && !mapped;
        if (setup_phase && !pwrite) begin
            s_nxt.prdata = rd_word;
        end
        // register writes take effect with the completing access
        if (wr_go && reg_hit(paddr, IDX_SETUP2)) begin
            s_nxt.lat = pwdata[LAT_LSB +: 2];
            s_nxt.s2_other = pwdata[5:0];
        end
        if (wr_go && reg_hit(paddr, IDX_SETUP3)) begin
            s_nxt.clamp_lvl = pwdata[CLAMP_LVL_LSB +: 4]; // RL3
            s_nxt.rs_shift = pwdata[RS_SHIFT_LSB +: 2]; // RL4
        end
        if (wr_go && reg_hit(paddr, IDX_SETUP4)) begin
            s_nxt.clamp_en = pwdata[CLAMP_EN_BIT]; // RL8
            s_nxt.colour = pwdata[COLOUR_LSB +: 2]; // RL9
        end
        if (wr_go && reg_hit(paddr, IDX_SETUP5)) begin
            s_nxt.det_en = pwdata[DET_EN_BIT];
            s_nxt.dly = pwdata[DLY_LSB +: 3];
            s_nxt.pol = pwdata[POL_BIT];
        end
        if (wr_go && reg_hit(paddr, IDX_MODE)) begin
            s_nxt.mode2 = pwdata[MODE2_BIT];
        end
        // converter clock divider, >= copes with a mode change mid count
        if (s_r.mode2) begin
            per = CONV_PER_MODE2; // RL2
        end
        if (s_r.conv_cnt >= per - 2'h1) begin
            s_nxt.conv_cnt = 2'h0;
            s_nxt.conv_tick = 1'b1;
        end else begin
            s_nxt.conv_cnt = s_r.conv_cnt + 2'h1;
            s_nxt.conv_tick = 1'b0;
        end
        // latency pipe advances once per converter period
        if (s_r.conv_tick) begin
            s_nxt.pipe = {s_r.pipe[2:0], conv_data_in};
        end
        s_nxt.data_out = s_r.pipe[s_r.lat]; // RL1
        // pass-through or generated pulse to timing control
        s_nxt.strobe_out = s_r.det_en ? det_pulse : sample_strobe_in; // RL11
        // per colour offset and gain
        s_nxt.offset_sel = pick_colour(s_r.colour, offset_red, // RL10
                                       offset_green, offset_blue);
        s_nxt.gain_sel = pick_colour(s_r.colour, gain_red, // RL10
                                     gain_green, gain_blue);
        // soft reset clears everything but the access in flight
        if (soft_go) begin
            v.pready = s_nxt.pready; // RL6
            v.pslverr = s_nxt.pslverr;
            v.prdata = s_nxt.prdata;
            s_nxt = v;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (reset) begin
            s_r <= state_reset();
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // outputs, all straight from the state register
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign conv_data_out = s_r.data_out;
    assign conv_tick = s_r.conv_tick;
    assign timing_strobe = s_r.strobe_out;
    assign clamp_level_code = s_r.clamp_lvl;
    assign reset_sample_shift = s_r.rs_shift;
    assign reset_level_clamping = s_r.clamp_en;
    assign colour_select = s_r.colour;
    assign offset_active = s_r.offset_sel;
    assign gain_active = s_r.gain_sel;

    // ======================================================================
    // checks
    a_lat_one_stage: assert property (@(posedge clock) // RL1
        disable iff (reset)
        s_r.lat == 2'h1 && !soft_go |=> conv_data_out == $past(s_r.pipe[1]))
        else $error("latency one does not take stage one");
    a_lat_three_stage: assert property (@(posedge clock) // RL1
        disable iff (reset)
        s_r.conv_tick && !soft_go ##1 (s_r.lat == 2'h3 && !soft_go)
        |=> conv_data_out == $past(s_r.pipe[2], 2))
        else $error("latency three does not lag three periods");
    a_conv_normal: assert property (@(posedge clock) // RL2
        disable iff (reset)
        conv_tick && !s_r.mode2 && !wr_go && !soft_go ##1 !wr_go
        |-> !conv_tick ##1 conv_tick)
        else $error("converter period not two clocks");
    a_conv_mode2: assert property (@(posedge clock) // RL2
        disable iff (reset)
        conv_tick && s_r.mode2 && !wr_go && !soft_go ##1 !wr_go ##1 !wr_go
        |-> $past(!conv_tick) && !conv_tick ##1 conv_tick)
        else $error("converter period not three clocks in mode two");
    a_clamp_lvl_reset: assert property (@(posedge clock) // RL3
        $past(reset) |-> clamp_level_code == 4'hF)
        else $error("clamp level code not all ones after reset");
    a_shift_write: assert property (@(posedge clock) // RL4
        disable iff (reset)
        wr_go && reg_hit(paddr, IDX_SETUP3)
        |=> reset_sample_shift == $past(pwdata[5:4]))
        else $error("reset sample shift not written");
    a_soft_clear: assert property (@(posedge clock) // RL6
        disable iff (reset)
        soft_go |=> clamp_level_code == 4'hF && reset_sample_shift == 2'h1
        && !reset_level_clamping && colour_select == 2'h0 && !s_r.det_en)
        else $error("soft reset left state set");
    a_clamp_write: assert property (@(posedge clock) // RL8
        disable iff (reset)
        wr_go && reg_hit(paddr, IDX_SETUP4)
        |=> reset_level_clamping == $past(pwdata[3])
        && colour_select == $past(pwdata[5:4]))
        else $error("setup four fields not written");
    a_colour_pick: assert property (@(posedge clock) // RL10
        disable iff (reset)
        colour_select == 2'h2 && !soft_go |=> offset_active ==
        $past(offset_blue) && gain_active == $past(gain_blue))
        else $error("blue selected but other values applied");
    a_strobe_pass: assert property (@(posedge clock) // RL11
        disable iff (reset)
        !s_r.det_en && !soft_go |=> timing_strobe == $past(sample_strobe_in))
        else $error("strobe not passed through with detection off");
    a_detect_quiet: assert property (@(posedge clock) // RL13
        disable iff (reset)
        !s_r.det_en ##1 !s_r.det_en |-> !det_pulse)
        else $error("detector active while disabled");
    a_lat_zero_stage: assert property (@(posedge clock) // RL1
        disable iff (reset)
        s_r.lat == 2'h0 && !soft_go |=> conv_data_out == $past(s_r.pipe[0]))
        else $error("latency zero does not take stage zero");
    a_lat_two_stage: assert property (@(posedge clock) // RL1
        disable iff (reset)
        s_r.lat == 2'h2 && !soft_go |=> conv_data_out == $past(s_r.pipe[2]))
        else $error("latency two does not take stage two");
    a_pipe_hold: assert property (@(posedge clock) // RL1
        disable iff (reset)
        !s_r.conv_tick && !soft_go |=> $stable(s_r.pipe))
        else $error("latency pipe moved without a converter tick");
    a_shift_reset: assert property (@(posedge clock) // RL4
        $past(reset) |-> reset_sample_shift == 2'h1)
        else $error("reset sample shift not nominal after reset");
    a_clamp_lvl_write: assert property (@(posedge clock) // RL3
        disable iff (reset)
        wr_go && reg_hit(paddr, IDX_SETUP3)
        |=> clamp_level_code == $past(pwdata[3:0]))
        else $error("clamp level code not written");
    a_colour_red: assert property (@(posedge clock) // RL10
        disable iff (reset)
        (colour_select == 2'h0 || colour_select == 2'h3) && !soft_go
        |=> offset_active == $past(offset_red)
        && gain_active == $past(gain_red))
        else $error("red or reserved selected but other values applied");
    a_colour_green: assert property (@(posedge clock) // RL10
        disable iff (reset)
        colour_select == 2'h1 && !soft_go |=> offset_active ==
        $past(offset_green) && gain_active == $past(gain_green))
        else $error("green selected but other values applied");
    a_detect_write: assert property (@(posedge clock) // RL12
        disable iff (reset)
        wr_go && reg_hit(paddr, IDX_SETUP5)
        |=> s_r.det_en == $past(pwdata[0]) && s_r.dly == $past(pwdata[3:1])
        && s_r.pol == $past(pwdata[4]))
        else $error("setup five fields not written");
    a_strobe_pulse: assert property (@(posedge clock) // RL11
        disable iff (reset)
        s_r.det_en && !soft_go |=> timing_strobe == $past(det_pulse))
        else $error("generated pulse not passed to timing control");
endmodule

// >>> rtl/afe_strobe_det.sv
// sample strobe edge detector with programmable delay
`timescale 1ns/1ps
module afe_strobe_det (
    input wire logic clock,
    input wire logic clear,
    input wire logic enable,
    input wire logic strobe_in,
    input wire logic polarity,
    input wire logic [2:0] delay,
    output logic pulse
);
    import afe_pkg::*;

    typedef struct packed {
        logic prev;
        logic [STROBE_DLY_MAX-2:0] pipe;
        logic pulse;
    } afe_det_state_s;

    afe_det_state_s s_r;
    afe_det_state_s s_nxt;
    logic edge_hit;

    // ======================================================================
    // edge compare against the previous sample
    assign edge_hit = polarity ? (strobe_in && !s_r.prev) // RL14
                               : (!strobe_in && s_r.prev); // RL16

    // next state: shift edges along, tap at the programmed delay
    always_comb begin
        s_nxt = s_r;
        s_nxt.prev = strobe_in; // RL16
        s_nxt.pipe = {s_r.pipe[STROBE_DLY_MAX-3:0], edge_hit};
        if (delay == 3'h0) begin
            s_nxt.pulse = edge_hit; // RL15
        end else begin
            s_nxt.pulse = s_r.pipe[delay - 3'h1]; // RL12
        end
        if (!enable) begin
            s_nxt.pipe = '0; // RL13
            s_nxt.pulse = 1'b0;
        end
    end

    // state register, a clear empties the pipe and the edge history
    always_ff @(posedge clock) begin
        if (clear) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pulse = s_r.pulse;

    // ======================================================================
    // checks
    a_zero_delay: assert property (@(posedge clock) disable iff (clear) // RL12
        enable && edge_hit && delay == 3'h0 |=> pulse)
        else $error("edge with zero delay gave no pulse");
    a_max_delay: assert property (@(posedge clock) disable iff (clear) // RL12
        enable && edge_hit && delay == 3'h7 ##1 (enable && delay == 3'h7)[*7]
        |=> pulse)
        else $error("edge with delay seven gave no pulse");
    a_pulse_one_wide: assert property (@(posedge clock) // RL15
        disable iff (clear)
        pulse ##1 $stable(delay) |-> !pulse)
        else $error("internal pulse wider than one clock");
    a_fall_only: assert property (@(posedge clock) disable iff (clear) // RL14
        enable && !polarity && !s_r.prev && delay == 3'h0 |=> !pulse)
        else $error("pulse without falling edge");
endmodule

// >>> tb/afe_host_model.sv
// host scan controller model that drives the sample strobe level
`timescale 1ns/1ps
module afe_host_model (
    input wire logic clock,
    output logic strobe
);
    // ======================================================================
    // strobe rests low until the host starts a line
    initial begin
        strobe = 1'b0;
    end
    // idle for a while, then inactive level, then the active edge
    // edges of one polarity are always at least two clocks apart
    task automatic edge_to(input logic level, input int idle);
        repeat (idle) @(posedge clock);
        @(posedge clock);
        strobe <= ~level;
        @(posedge clock);
        strobe <= level;
    endtask
endmodule

// >>> tb/afe_setup_regs_sample_sync_bench.sv
// self-checking bench for the setup registers and strobe detector
`timescale 1ns/1ps
module afe_setup_regs_sample_sync_bench;
    import afe_pkg::*;
    // ======================================================================
    // design signals and counters
    logic clock, reset, psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] conv_data_out;
    logic [15:0] conv_data_in = 16'h0000;
    logic conv_tick, sample_strobe_in, timing_strobe;
    logic [3:0] clamp_level_code;
    logic [1:0] reset_sample_shift, colour_select;
    logic reset_level_clamping;
    logic [7:0] offset_red, offset_green, offset_blue;
    logic [7:0] gain_red, gain_green, gain_blue;
    logic [7:0] offset_active, gain_active;
    int fail_count = 0;
    int n_checks = 0;

    afe_setup_regs #(.DATA_W(16)) dut (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_data_in(conv_data_in), .conv_data_out(conv_data_out),
        .conv_tick(conv_tick), .sample_strobe_in(sample_strobe_in),
        .timing_strobe(timing_strobe),
        .clamp_level_code(clamp_level_code),
        .reset_sample_shift(reset_sample_shift),
        .reset_level_clamping(reset_level_clamping),
        .colour_select(colour_select), .offset_red(offset_red),
        .offset_green(offset_green), .offset_blue(offset_blue),
        .gain_red(gain_red), .gain_green(gain_green),
        .gain_blue(gain_blue), .offset_active(offset_active),
        .gain_active(gain_active)
    );
    afe_host_model host (.clock(clock), .strobe(sample_strobe_in));

    // ======================================================================
    // 40 MHz clock and a converter input that changes every clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        conv_data_in <= conv_data_in + 16'h0001;
    end

    // ======================================================================
    // comparison, verdict and bus tasks
    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // output pins share the same reporting
    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        chk_bus(got, exp);
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one transfer: setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic e);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk_bus(rd, exp);
        chk_bus({31'h0, err}, {31'h0, e});
    endtask
    // tick spacing and output delay of one sample through the pipe
    task automatic lat_chk(input int per, input int lat);
        logic [15:0] v, d;
        int n, gap;
        repeat (2) begin
            @(negedge clock);
            n = 0;
            while (conv_tick !== 1'b1 && n < 9) begin
                @(negedge clock);
                n++;
            end
        end
        v = conv_data_in;
        gap = 0;
        for (int k = 1; k <= 2 + lat * per + per; k++) begin
            @(negedge clock);
            if (conv_tick === 1'b1 && gap == 0) gap = k;
            if (k == 2 + lat * per) d = conv_data_out;
        end
        chk_pin(gap, per);
        chk_pin(d, v);
    endtask
    // one strobe edge, then the timing strobe over the whole window
    task automatic strb_chk(input logic det, input logic pol,
                            input logic [2:0] dly);
        logic exp;
        wr_reg(8'h20, {27'h0, pol, dly, det});
        host.edge_to(pol, dly);
        for (int k = 0; k <= dly + 4; k++) begin
            @(negedge clock);
            exp = det ? (k == dly + 2) : (k >= 1 ? pol : ~pol);
            chk_pin(timing_strobe, exp);
        end
    endtask

    // ======================================================================
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        complete_run();
    end

    // ======================================================================
    // main sequence
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        {offset_red, offset_green, offset_blue} = '0;
        {gain_red, gain_green, gain_blue} = '0;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        wr_reg(8'h10, 32'h0000_0000);
        rd_chk(8'h0C, 32'h0000_001F, 1'b0);
        rd_chk(8'h18, 32'h0000_0005, 1'b0);
        rd_chk(8'h20, 32'h0000_0000, 1'b0);
        @(negedge clock);
        chk_pin(clamp_level_code, 4'hF);
        chk_pin(reset_sample_shift, 2'h1);
        $display("test reset_values done");
        for (int s = 0; s < 4; s++) begin
            wr_reg(8'h0C, {26'h0, s[1:0], s[3:0] ^ 4'h5});
            @(negedge clock);
            chk_pin(clamp_level_code, s[3:0] ^ 4'h5);
            chk_pin(reset_sample_shift, s[1:0]);
            rd_chk(8'h0C, {26'h0, s[1:0], s[3:0] ^ 4'h5}, 1'b0);
        end
        $display("test clamp_timing done");
        for (int c = 0; c < 4; c++) begin
            @(posedge clock);
            offset_red <= {c[3:0], 4'h1};
            offset_green <= {c[3:0], 4'h2};
            offset_blue <= {c[3:0], 4'h3};
            gain_red <= {c[3:0], 4'h4};
            gain_green <= {c[3:0], 4'h5};
            gain_blue <= {c[3:0], 4'h6};
            wr_reg(8'h18, {26'h0, c[1:0], c[0], 3'h5});
            repeat (2) @(negedge clock); // pick lags the select a clock
            chk_pin(colour_select, c[1:0]);
            chk_pin(reset_level_clamping, c[0]);
            chk_pin(offset_active, {c[3:0], (c == 1) ? 4'h2 :
                    (c == 2) ? 4'h3 : 4'h1});
            chk_pin(gain_active, {c[3:0], (c == 1) ? 4'h5 :
                    (c == 2) ? 4'h6 : 4'h4});
            rd_chk(8'h18, {26'h0, c[1:0], c[0], 3'h5}, 1'b0);
        end
        $display("test colour_clamp done");
        rd_chk(8'h04, 32'h0000_0000, 1'b1);
        rd_chk(8'h10, 32'h0000_0000, 1'b0);
        $display("test bus_errors done");
        for (int m = 0; m < 2; m++) begin
            wr_reg(8'h34, m);
            for (int l = 0; l < 4; l++) begin
                wr_reg(8'h08, {24'h0, l[1:0], 6'h23});
                lat_chk(2 + m, l);
            end
        end
        $display("test latency done");
        strb_chk(1'b0, 1'b1, 3'h7);
        strb_chk(1'b0, 1'b0, 3'h7);
        for (int p = 0; p < 2; p++) begin
            for (int d = 0; d < 8; d++) begin
                strb_chk(1'b1, p[0], d[2:0]);
            end
        end
        $display("test strobe done");
        wr_reg(8'h0C, 32'h0000_002A);
        wr_reg(8'h08, 32'h0000_00E3);
        wr_reg(8'h10, 32'h0000_00A5);
        @(negedge clock);
        chk_pin(clamp_level_code, 4'hF);
        chk_pin(colour_select, 2'h0);
        rd_chk(8'h08, 32'h0000_0023, 1'b0);
        rd_chk(8'h20, 32'h0000_0000, 1'b0);
        rd_chk(8'h34, 32'h0000_0000, 1'b0);
        $display("test soft_reset done");
        complete_run();
    end
endmodule
